// >>> pxc_regs.vh
// register offsets, field positions, reset values and timing counts of the proximity config bank
`ifndef PXC_REGS_VH
`define PXC_REGS_VH

`define PXC_ADDR_W 8
`define PXC_DATA_W 8

`define PXC_OFS_CH_CFG 8'hAF
`define PXC_OFS_FP_CFG 8'hB0
`define PXC_OFS_OFFSET_LO 8'hB1
`define PXC_OFS_OFFSET_HI 8'hB2
`define PXC_OFS_AVG_LO 8'hB3
`define PXC_OFS_AVG_HI 8'hB4
`define PXC_OFS_BSLN_LO 8'hB5
`define PXC_OFS_BSLN_HI 8'hB6
`define PXC_OFS_IRQ_STATUS 8'hC0
`define PXC_OFS_IRQ_MASK 8'hC1
`define PXC_OFS_RES0_LO 8'hC2
`define PXC_OFS_RES0_HI 8'hC3
`define PXC_OFS_RES1_LO 8'hC4
`define PXC_OFS_RES1_HI 8'hC5

`define PXC_CH_SEL_BIT 7
`define PXC_CH1_HIGH_BIT 3
`define PXC_CH1_LOW_BIT 2
`define PXC_CH0_HIGH_BIT 1
`define PXC_CH0_LOW_BIT 0
`define PXC_SUM_BIT 4
`define PXC_PW_MSB 2
`define PXC_PW_LSB 0

`define PXC_CH_CFG_RST 8'h00
`define PXC_FP_CFG_RST 8'h01
`define PXC_CH_CFG_MASK 8'h8F
`define PXC_FP_CFG_MASK 8'h17
`define PXC_WORD_RST 16'h0000

`define PXC_ST_COND 0
`define PXC_ST_RESULT 1
`define PXC_ST_PULSE 2
`define PXC_ST_W 3

`define PXC_CLK_PERIOD_NS 10
`define PXC_PULSE_BASE_NS 4000
`define PXC_PULSE_BASE_CYC (`PXC_PULSE_BASE_NS / `PXC_CLK_PERIOD_NS)

`endif

// >>> pxc_config_regs.v
// proximity engine configuration register bank with result pre-filter, interrupt combine and pulse timer
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "pxc_regs.vh"

////////////////////////////////////////////////////////////////////////////////

module pxc_config_regs #(
  parameter integer DATA_W = 16,
  parameter integer PULSE_BASE_CYC = `PXC_PULSE_BASE_CYC,
  parameter integer PULSE_CNT_W = 17
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [`PXC_ADDR_W-1:0] reg_addr,
  input wire [`PXC_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`PXC_DATA_W-1:0] reg_rdata,
  input wire sample_valid,
  input wire [DATA_W-1:0] raw_channel_zero,
  input wire [DATA_W-1:0] raw_channel_one,
  input wire ch0_low_hit,
  input wire ch0_high_hit,
  input wire ch1_low_hit,
  input wire ch1_high_hit,
  input wire pulse_req,
  output reg [DATA_W-1:0] result_channel_zero,
  output reg [DATA_W-1:0] result_channel_one,
  output reg result_valid,
  output reg [DATA_W-1:0] baseline_sample,
  output reg prox_int_cond,
  output reg emitter_drive,
  output reg [PULSE_CNT_W-1:0] emitter_pulse_cycles,
  output reg [DATA_W-1:0] offset_zero_value,
  output reg [DATA_W-1:0] average_value,
  output reg [DATA_W-1:0] baseline_value,
  output wire irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // saturating add; a sum just past full scale would otherwise wrap to a small value
  function [DATA_W-1:0] sat_add;
    input [DATA_W-1:0] a;
    input [DATA_W-1:0] b;
    reg [DATA_W:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      sat_add = s[DATA_W] ? {DATA_W{1'b1}} : s[DATA_W-1:0];
    end
  endfunction

  // 16-bit register written one byte at a time, low byte at the lower offset
  function [DATA_W-1:0] byte_merge;
    input [DATA_W-1:0] cur;
    input hi;
    input [7:0] d;
    begin
      byte_merge = hi ? {d, cur[7:0]} : {cur[DATA_W-1:8], d};
    end
  endfunction

  // a byte write lands in the half picked by the address; any other offset leaves the word alone
  function [DATA_W-1:0] word_write;
    input [DATA_W-1:0] cur;
    input [`PXC_ADDR_W-1:0] addr;
    input [`PXC_ADDR_W-1:0] lo_ofs;
    input [7:0] d;
    begin
      if (addr == lo_ofs) begin
        word_write = byte_merge(cur, 1'b0, d);
      end else if (addr == lo_ofs + 8'h01) begin
        word_write = byte_merge(cur, 1'b1, d);
      end else begin
        word_write = cur;
      end
    end
  endfunction

  // read side of the same split, high half at the upper offset
  function [7:0] byte_pick;
    input [DATA_W-1:0] word;
    input hi;
    begin
      byte_pick = hi ? word[DATA_W-1:8] : word[7:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // register storage

  reg [7:0] channel_combine_config_reg;
  reg [7:0] filter_pulse_config_reg;
  reg [`PXC_ST_W-1:0] irq_status_reg;
  reg [`PXC_ST_W-1:0] irq_mask_reg;
  reg [DATA_W-1:0] prev_channel_zero_reg;
  reg [DATA_W-1:0] prev_channel_one_reg;
  reg cond_prev_reg;
  reg [PULSE_CNT_W-1:0] pulse_cnt_reg;

  wire wr_ch_cfg = reg_wr && (reg_addr == `PXC_OFS_CH_CFG);
  wire wr_fp_cfg = reg_wr && (reg_addr == `PXC_OFS_FP_CFG);
  wire wr_status = reg_wr && (reg_addr == `PXC_OFS_IRQ_STATUS);
  wire wr_mask = reg_wr && (reg_addr == `PXC_OFS_IRQ_MASK);

  wire baseline_channel_select = channel_combine_config_reg[`PXC_CH_SEL_BIT];
  wire ch1_high_combine = channel_combine_config_reg[`PXC_CH1_HIGH_BIT];
  wire ch1_low_combine = channel_combine_config_reg[`PXC_CH1_LOW_BIT];
  wire ch0_high_combine = channel_combine_config_reg[`PXC_CH0_HIGH_BIT];
  wire ch0_low_combine = channel_combine_config_reg[`PXC_CH0_LOW_BIT];
  wire dual_integration_sum = filter_pulse_config_reg[`PXC_SUM_BIT];
  wire [2:0] emitter_pulse_width = filter_pulse_config_reg[`PXC_PW_MSB:`PXC_PW_LSB];

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      channel_combine_config_reg <= `PXC_CH_CFG_RST;
      filter_pulse_config_reg <= `PXC_FP_CFG_RST;
    end else begin
      // reserved bits are not stored so they read back as zero
      if (wr_ch_cfg) begin
        channel_combine_config_reg <= reg_wdata & `PXC_CH_CFG_MASK;
      end
      if (wr_fp_cfg) begin
        filter_pulse_config_reg <= reg_wdata & `PXC_FP_CFG_MASK;
      end
    end
  end

  // mask is kept apart from the config bytes; it only gates the interrupt pin
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_mask_reg <= {`PXC_ST_W{1'b0}};
    end else if (wr_mask) begin
      irq_mask_reg <= reg_wdata[`PXC_ST_W-1:0];
    end
  end

  // host-only words: the engine never writes them, so a plain byte merge is enough
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      offset_zero_value <= `PXC_WORD_RST;
      average_value <= `PXC_WORD_RST;
      baseline_value <= `PXC_WORD_RST;
    end else if (reg_wr) begin
      offset_zero_value <= word_write(offset_zero_value, reg_addr, `PXC_OFS_OFFSET_LO, reg_wdata);
      average_value <= word_write(average_value, reg_addr, `PXC_OFS_AVG_LO, reg_wdata);
      baseline_value <= word_write(baseline_value, reg_addr, `PXC_OFS_BSLN_LO, reg_wdata);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // result path

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      prev_channel_zero_reg <= `PXC_WORD_RST;
      prev_channel_one_reg <= `PXC_WORD_RST;
      result_channel_zero <= `PXC_WORD_RST;
      result_channel_one <= `PXC_WORD_RST;
      result_valid <= 1'b0;
    end else begin
      result_valid <= sample_valid;
      if (sample_valid) begin
        // raw history is kept even with the filter off so enabling it sums real data at once
        prev_channel_zero_reg <= raw_channel_zero;
        prev_channel_one_reg <= raw_channel_one;
        if (dual_integration_sum) begin
          result_channel_zero <= sat_add(raw_channel_zero, prev_channel_zero_reg);
          result_channel_one <= sat_add(raw_channel_one, prev_channel_one_reg);
        end else begin
          result_channel_zero <= raw_channel_zero;
          result_channel_one <= raw_channel_one;
        end
      end
    end
  end

  // the baseline tap trails the results by a cycle so it always picks from a settled pair
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      baseline_sample <= `PXC_WORD_RST;
    end else if (result_valid) begin
      baseline_sample <= baseline_channel_select ? result_channel_one : result_channel_zero;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt condition

  reg [3:0] hit_vec;
  reg [3:0] and_sel;
  reg or_term;
  reg and_term;
  reg cond_next;

  always @* begin
    hit_vec = {ch1_high_hit, ch1_low_hit, ch0_high_hit, ch0_low_hit};
    and_sel[3] = ch1_high_combine;
    and_sel[2] = ch1_low_combine;
    and_sel[1] = ch0_high_combine;
    and_sel[0] = ch0_low_combine;
    or_term = |(hit_vec & ~and_sel);
    and_term = (|and_sel) && ((hit_vec | ~and_sel) == 4'hF);
    cond_next = or_term || and_term;
  end

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      prox_int_cond <= 1'b0;
      cond_prev_reg <= 1'b0;
    end else begin
      // hit flags are only meaningful beside a sample, so the condition is held between samples
      if (sample_valid) begin
        prox_int_cond <= cond_next;
      end
      cond_prev_reg <= prox_int_cond;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // emitter pulse timer

  localparam [1:0] PS_IDLE = 2'b01;
  localparam [1:0] PS_DRIVE = 2'b10;
  localparam [PULSE_CNT_W-1:0] CNT_ONE = {{(PULSE_CNT_W-1){1'b0}}, 1'b1};

  reg [1:0] pulse_state_reg;
  reg [1:0] pulse_state_next;
  reg [PULSE_CNT_W-1:0] pulse_cnt_next;

  wire [PULSE_CNT_W-1:0] pulse_len = PULSE_BASE_CYC[PULSE_CNT_W-1:0] << emitter_pulse_width;
  wire pulse_done = pulse_state_reg[1] && (pulse_cnt_reg == CNT_ONE);

  always @* begin
    pulse_state_next = pulse_state_reg;
    pulse_cnt_next = pulse_cnt_reg;
    case (pulse_state_reg)
      PS_IDLE: begin
        // the length is latched here, so a code change mid-pulse only shapes the next pulse
        if (pulse_req) begin
          pulse_state_next = PS_DRIVE;
          pulse_cnt_next = pulse_len;
        end
      end
      PS_DRIVE: begin
        // a request during a running pulse is dropped, not queued
        pulse_cnt_next = pulse_cnt_reg - CNT_ONE;
        if (pulse_done) begin
          pulse_state_next = PS_IDLE;
        end
      end
      default: begin
        pulse_state_next = PS_IDLE;
        pulse_cnt_next = {PULSE_CNT_W{1'b0}};
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      pulse_state_reg <= PS_IDLE;
      pulse_cnt_reg <= {PULSE_CNT_W{1'b0}};
      emitter_drive <= 1'b0;
      emitter_pulse_cycles <= {PULSE_CNT_W{1'b0}};
    end else begin
      pulse_state_reg <= pulse_state_next;
      pulse_cnt_reg <= pulse_cnt_next;
      emitter_drive <= pulse_state_next[1];
      emitter_pulse_cycles <= pulse_len;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status, set wins over write-one clear

  reg [`PXC_ST_W-1:0] st_set;

  always @* begin
    st_set = {`PXC_ST_W{1'b0}};
    // the condition reports its rising edge only, so a held condition is one event
    st_set[`PXC_ST_COND] = prox_int_cond & ~cond_prev_reg;
    st_set[`PXC_ST_RESULT] = result_valid;
    st_set[`PXC_ST_PULSE] = pulse_done;
  end

  wire [`PXC_ST_W-1:0] st_clr = wr_status ? reg_wdata[`PXC_ST_W-1:0] : {`PXC_ST_W{1'b0}};

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_status_reg <= {`PXC_ST_W{1'b0}};
    end else begin
      irq_status_reg <= (irq_status_reg & ~st_clr) | st_set;
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  ////////////////////////////////////////////////////////////////////////////////
  // read port, data in the cycle after the strobe only

  reg [7:0] rd_mux;

  always @* begin
    case (reg_addr)
      `PXC_OFS_CH_CFG: rd_mux = channel_combine_config_reg;
      `PXC_OFS_FP_CFG: rd_mux = filter_pulse_config_reg;
      `PXC_OFS_OFFSET_LO: rd_mux = byte_pick(offset_zero_value, 1'b0);
      `PXC_OFS_OFFSET_HI: rd_mux = byte_pick(offset_zero_value, 1'b1);
      `PXC_OFS_AVG_LO: rd_mux = byte_pick(average_value, 1'b0);
      `PXC_OFS_AVG_HI: rd_mux = byte_pick(average_value, 1'b1);
      `PXC_OFS_BSLN_LO: rd_mux = byte_pick(baseline_value, 1'b0);
      `PXC_OFS_BSLN_HI: rd_mux = byte_pick(baseline_value, 1'b1);
      `PXC_OFS_IRQ_STATUS: rd_mux = {{(8-`PXC_ST_W){1'b0}}, irq_status_reg};
      `PXC_OFS_IRQ_MASK: rd_mux = {{(8-`PXC_ST_W){1'b0}}, irq_mask_reg};
      `PXC_OFS_RES0_LO: rd_mux = byte_pick(result_channel_zero, 1'b0);
      `PXC_OFS_RES0_HI: rd_mux = byte_pick(result_channel_zero, 1'b1);
      `PXC_OFS_RES1_LO: rd_mux = byte_pick(result_channel_one, 1'b0);
      `PXC_OFS_RES1_HI: rd_mux = byte_pick(result_channel_one, 1'b1);
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

endmodule

`default_nettype wire

// >>> pxc_checker.sv
// concurrent checks of the proximity config bank ports
`timescale 1ns/1ps
`default_nettype none
module pxc_checker #(
  parameter integer DATA_W = 16,
  parameter integer PULSE_BASE_CYC = 400,
  parameter integer PULSE_CNT_W = 17
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic sample_valid,
  input wire logic [DATA_W-1:0] raw_channel_zero,
  input wire logic ch0_low_hit,
  input wire logic ch0_high_hit,
  input wire logic ch1_low_hit,
  input wire logic ch1_high_hit,
  input wire logic pulse_req,
  input wire logic [DATA_W-1:0] result_channel_zero,
  input wire logic result_valid,
  input wire logic [DATA_W-1:0] baseline_sample,
  input wire logic prox_int_cond,
  input wire logic emitter_drive,
  input wire logic [PULSE_CNT_W-1:0] emitter_pulse_cycles
);
  ////////////////////////////////////////
  // shadow copies of the two config bytes, rebuilt from the bus
  logic [7:0] cc_q;
  logic [7:0] fp_q;
  logic [PULSE_CNT_W-1:0] hi_cnt;
  logic [3:0] hv;
  assign hv = {ch1_high_hit, ch1_low_hit, ch0_high_hit, ch0_low_hit};
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      cc_q <= 8'h00;
      fp_q <= 8'h01;
      hi_cnt <= '0;
    end else begin
      if (reg_wr && reg_addr == 8'hAF) cc_q <= reg_wdata;
      if (reg_wr && reg_addr == 8'hB0) fp_q <= reg_wdata;
      hi_cnt <= emitter_drive ? hi_cnt + 1'b1 : '0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    sample_valid ##1 result_valid;
  endsequence
  property p_rv; sample_valid |=> result_valid; endproperty
  a_rv: assert property (p_rv) else $error("no result_valid");
  property p_one; sample_valid && !fp_q[4] |=> result_channel_zero == $past(raw_channel_zero); endproperty
  a_one: assert property (p_one) else $error("single result wrong");
  property p_bs0; (s_take ##0 !cc_q[7]) |=> baseline_sample == $past(result_channel_zero); endproperty
  a_bs0: assert property (p_bs0) else $error("baseline source wrong");
  property p_or; sample_valid && cc_q[3:0] == 4'h0 |=> prox_int_cond == $past(|hv); endproperty
  a_or: assert property (p_or) else $error("plain terms not ORed");
  property p_and; sample_valid && cc_q[3:0] == 4'hF |=> prox_int_cond == $past(&hv); endproperty
  a_and: assert property (p_and) else $error("combined terms wrong");
  property p_req; pulse_req && !emitter_drive |=> emitter_drive; endproperty
  a_req: assert property (p_req) else $error("pulse not started");
  property p_pw; $rose(emitter_drive) |-> emitter_pulse_cycles == PULSE_BASE_CYC << fp_q[2:0]; endproperty
  a_pw: assert property (p_pw) else $error("pulse length code wrong");
  property p_len; $fell(emitter_drive) |-> hi_cnt == emitter_pulse_cycles; endproperty
  a_len: assert property (p_len) else $error("pulse high time wrong");
endmodule
bind pxc_config_regs pxc_checker #(.DATA_W(DATA_W), .PULSE_BASE_CYC(PULSE_BASE_CYC), .PULSE_CNT_W(PULSE_CNT_W))
  pxc_checker_inst (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .sample_valid, .raw_channel_zero,
  .ch0_low_hit, .ch0_high_hit, .ch1_low_hit, .ch1_high_hit, .pulse_req, .result_channel_zero,
  .result_valid, .baseline_sample, .prox_int_cond, .emitter_drive, .emitter_pulse_cycles);
`default_nettype wire

// >>> pxc_engine_model.sv
// engine-side model handing integrations and threshold hits to the bank
`timescale 1ns/1ps
`default_nettype none
module pxc_engine_model (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [15:0] raw0_in,
  input wire logic [15:0] raw1_in,
  input wire logic [3:0] hit_in,
  output logic sample_valid,
  output logic [15:0] raw_channel_zero,
  output logic [15:0] raw_channel_one,
  output logic [3:0] hits
);
  ////////////////////////////////////////
  // off-strobe lines toggle so stale sampling shows up as garbage
  logic [35:0] last = '0;
  always @(posedge ref_clk) last <= {raw_channel_zero, raw_channel_one, hits};
  assign sample_valid = go;
  assign {raw_channel_zero, raw_channel_one, hits} = go ? {raw0_in, raw1_in, hit_in} : ~last;
endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the proximity config bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pulse_req = 1'b0;
  logic go = 1'b0;
  logic [15:0] r0 = 16'h0000;
  logic [15:0] r1 = 16'h0000;
  logic [3:0] hin = 4'h0;
  logic [3:0] hv;
  logic [7:0] reg_rdata;
  logic sv, result_valid, prox_int_cond, emitter_drive, irq;
  logic [15:0] raw0, raw1, res0, res1, bsl;
  logic [15:0] ofs, avg, bsv;
  logic [16:0] pcyc;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  localparam logic [7:0] AD [9] = '{8'hAF, 8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB5, 8'hB6, 8'h10};
  localparam logic [7:0] WM [9] = '{8'h8F, 8'h17, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
  ////////////////////////////////////////
  // short base count keeps the longest pulse at 512 cycles
  pxc_config_regs #(.PULSE_BASE_CYC(4)) pxc_config_regs_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_valid(sv), .raw_channel_zero(raw0), .raw_channel_one(raw1), .ch0_low_hit(hv[0]),
    .ch0_high_hit(hv[1]), .ch1_low_hit(hv[2]), .ch1_high_hit(hv[3]), .pulse_req(pulse_req),
    .result_channel_zero(res0), .result_channel_one(res1), .result_valid(result_valid),
    .baseline_sample(bsl), .prox_int_cond(prox_int_cond), .emitter_drive(emitter_drive),
    .emitter_pulse_cycles(pcyc), .offset_zero_value(ofs), .average_value(avg), .baseline_value(bsv),
    .irq(irq));
  pxc_engine_model pxc_engine_model_inst (.ref_clk(ref_clk), .go(go), .raw0_in(r0), .raw1_in(r1),
    .hit_in(hin), .sample_valid(sv), .raw_channel_zero(raw0), .raw_channel_one(raw1), .hits(hv));
  initial forever #5 ref_clk = ~ref_clk;
  task automatic results;
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 10000) begin
      num_errors++;
      results;
    end
  end
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %0h got %0h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 cmp("reg_rdata", e, reg_rdata);
  endtask
  task automatic smp(input logic [15:0] a, input logic [15:0] b, input logic [3:0] h);
    @(posedge ref_clk);
    go <= 1'b1;
    r0 <= a;
    r1 <= b;
    hin <= h;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic t_regs;
    cmp("pulse_cycles", 8, pcyc);
    for (int i = 0; i < 9; i++) begin
      rd(AD[i], i == 1 ? 8'h01 : 8'h00);
      wr(AD[i], 8'hFF);
      rd(AD[i], WM[i]);
    end
    cmp("offset_zero_value", 16'hFFFF, ofs);
    cmp("average_value", 16'hFFFF, avg);
    cmp("baseline_value", 16'hFFFF, bsv);
    wr(8'hAF, 8'h00);
    wr(8'hB0, 8'h01);
  endtask
  task automatic t_sum;
    wr(8'hB0, 8'h11);
    smp(16'h0003, 16'hFFFF, 4'h0);
    smp(16'h0005, 16'h0002, 4'h0);
    cmp("res0", 16'h0008, res0);
    cmp("res1", 16'hFFFF, res1);
    wr(8'hC2, 8'h55);
    rd(8'hC2, 8'h08);
    rd(8'hC3, 8'h00);
    rd(8'hC5, 8'hFF);
    wr(8'hB0, 8'h01);
    smp(16'h0007, 16'h0001, 4'h0);
    cmp("res0", 16'h0007, res0);
    cmp("baseline", 16'h0007, bsl);
    wr(8'hAF, 8'h80);
    smp(16'h0009, 16'h0004, 4'h0);
    cmp("baseline", 16'h0004, bsl);
  endtask
  task automatic t_comb;
    logic exp_c;
    for (int c = 0; c < 16; c++) begin
      wr(8'hAF, 8'(c));
      for (int h = 0; h < 16; h++) begin
        smp(16'h0001, 16'h0001, 4'(h));
        exp_c = (|(h & ~c & 15)) || (c != 0 && (h & c) == c);
        cmp("cond", exp_c, prox_int_cond);
      end
    end
    wr(8'hAF, 8'h00);
  endtask
  task automatic t_pulse;
    int n;
    wr(8'hC0, 8'h07);
    wr(8'hC1, 8'h04);
    for (int k = 0; k < 8; k++) begin
      wr(8'hB0, 8'(k));
      @(posedge ref_clk);
      pulse_req <= 1'b1;
      @(posedge ref_clk);
      pulse_req <= 1'b0;
      n = 0;
      #1;
      while (emitter_drive === 1'b1 && n < 600) begin
        n++;
        @(posedge ref_clk);
        #1;
      end
      cmp("pulse_len", 4 << k, n);
    end
    @(posedge ref_clk);
    #1 cmp("irq", 1, irq);
    rd(8'hC0, 8'h04);
    wr(8'hC0, 8'h04);
    #1 cmp("irq", 0, irq);
    // masked event must stay silent even though the status bit sets
    wr(8'hC1, 8'h00);
    smp(16'h0001, 16'h0001, 4'h0);
    cmp("irq", 0, irq);
    rd(8'hC0, 8'h02);
  endtask
  // mid-run reset must bring the two config bytes, the pulse length and the baseline host word back
  task automatic t_rst;
    wr(8'hAF, 8'h81);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1 cmp("pulse_cycles", 0, pcyc);
    rd(8'hAF, 8'h00);
    rd(8'hB0, 8'h01);
    cmp("pulse_cycles", 8, pcyc);
    cmp("baseline_value", 16'h0000, bsv);
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    t_regs;
    t_sum;
    t_comb;
    t_pulse;
    t_rst;
    results;
  end
endmodule
`default_nettype wire
